/* File: include/pwm_edge_pkg.sv */
// Purpose: constants for the multimode pwm edge engine
// Assumes: 16-bit counter domain, 32-bit axi4-lite register bus
// Notes on behaviour
// - normal mode: A rises at event 1, falls at event 1 + duty + adjust A.
// - normal mode: B rises at A fall + (event 3 - event 2), falls at event 4.
// - adaptive trigger at event 1 + duty (or duty/2) + offset, in normal/multi/resonant.
// - phase trigger from fixed register or live filter duty, by configuration.
// - sample triggers 1,2 and blanking A/B begin/end come straight from registers.
// - adjust B never affects edges in normal mode.
// - multi mode: A as normal; B rises at event 3, falls at event 3 + duty + adjust B.
// - multi mode ignores events 2 and 4.
// - multi mode: B may wrap past period end keeping width; A never wraps.
// - resonant: dead1 = e3 - e2, dead2 = e1 + period - e4, average is half sum.
// - resonant: A rises e1, falls e1 + duty - avg; B rises there + (e3 - e2).
// - resonant: B falls at filter period - (period - event 4).
// - triangular: B rises period/2 - duty/2 + adjA, falls period/2 + duty/2 + adjB.
// - triangular: output A idle and no adaptive trigger.
// - leading edge: A falls at e1, rises at e1 - duty + adjust A.
// - leading edge: B rises e4, falls at A rise - (e2 - e3).
// - leading edge: adaptive trigger at e1 - duty (or duty/2) + offset.
// - period counter counts from zero up to period limit then restarts.
// - each signal changes when the counter equals its computed target.
package pwm_edge_pkg;
  localparam int CW = 16;
  localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_EV1    = 8'h08;
  localparam logic [7:0] OFF_EV2    = 8'h0c;
  localparam logic [7:0] OFF_EV3    = 8'h10;
  localparam logic [7:0] OFF_EV4    = 8'h14;
  localparam logic [7:0] OFF_ADJA   = 8'h18;
  localparam logic [7:0] OFF_ADJB   = 8'h1c;
  localparam logic [7:0] OFF_ADAPT  = 8'h20;
  localparam logic [7:0] OFF_PHASE  = 8'h24;
  localparam logic [7:0] OFF_SAMP1  = 8'h28;
  localparam logic [7:0] OFF_SAMP2  = 8'h2c;
  localparam logic [7:0] OFF_BLKAB  = 8'h30;
  localparam logic [7:0] OFF_BLKAE  = 8'h34;
  localparam logic [7:0] OFF_BLKBB  = 8'h38;
  localparam logic [7:0] OFF_BLKBE  = 8'h3c;
  localparam logic [7:0] OFF_STATUS = 8'h40;
  // control fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int CTRL_HALF_BIT  = 4;
  localparam int CTRL_PHSEL_BIT = 5;
  localparam logic [CW-1:0] PERIOD_RST = 16'h00ff;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b000,
    MODE_MULTI    = 3'b001,
    MODE_RESONANT = 3'b010,
    MODE_TRIANGLE = 3'b011,
    MODE_LEADING  = 3'b100
  } pwm_mode_t;
endpackage

/* File: verilog/edge_match.sv */
`timescale 1ns/1ps
// Purpose: registered compare of counter against a target position
// Assumes: counter and target share one width
// Notes: gated by enable so idle targets never fire
module edge_match
  import pwm_edge_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic          reset_n_i,
  input  wire logic          en_i,
  input  wire logic [CW-1:0] count_i,
  input  wire logic [CW-1:0] target_i,
  output logic               hit_o
);
  // one pulse when the counter reaches the target
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= en_i && (count_i == target_i);
    end
  end
endmodule

/* File: verilog/multimode_pwm_edge_engine.sv */
`timescale 1ns/1ps
// Purpose: edge engine for a two-output pwm with five modes
// Assumes: filter duty and period are synchronous inputs held steady
// Notes: pulses lag the counter match by one cycle; levels by two (match flop, then output flop)
module multimode_pwm_edge_engine
  import pwm_edge_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic          reset_n_i,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic [CW-1:0] filter_duty_i,
  input  wire logic [CW-1:0] filter_period_i,
  output logic               pwm_output_first_o,
  output logic               pwm_output_second_o,
  output logic               adaptive_trig_o,
  output logic               phase_trig_o,
  output logic               sample_trig1_o,
  output logic               sample_trig2_o,
  output logic               blank_a_o,
  output logic               blank_b_o,
  output logic               period_start_o
);
  // register file
  localparam int NREG = 16;
  logic [CW-1:0] regs_ff [NREG];
  logic [5:0]    ctrl_ff;
  logic [CW-1:0] count_ff;
  logic          bpend_ff;
  logic          rpend_ff;
  logic [7:0]    awaddr_ff;
  logic [31:0]   wdata_ff;
  logic          aw_ff;
  logic          w_ff;
  logic          wrap_ff;

  wire logic      enable  = ctrl_ff[CTRL_EN_BIT];
  wire pwm_mode_t mode    = pwm_mode_t'(ctrl_ff[CTRL_MODE_LSB +: 3]);
  wire logic      half_sel = ctrl_ff[CTRL_HALF_BIT];
  wire logic      ph_sel  = ctrl_ff[CTRL_PHSEL_BIT];
  wire logic [CW-1:0] period = regs_ff[1];
  wire logic [CW-1:0] ev1 = regs_ff[2];
  wire logic [CW-1:0] ev2 = regs_ff[3];
  wire logic [CW-1:0] ev3 = regs_ff[4];
  wire logic [CW-1:0] ev4 = regs_ff[5];
  wire logic [CW-1:0] adja = regs_ff[6];
  wire logic [CW-1:0] adjb = regs_ff[7];
  wire logic [CW-1:0] adapt = regs_ff[8];
  wire logic [CW-1:0] phreg = regs_ff[9];

  // wraps a position into the counter range; no modulo, one subtraction suffices
  function automatic logic [CW-1:0] wrap_pos(input logic [CW:0] pos,
                                             input logic [CW-1:0] period_limit);
    logic [CW:0] lim;
    lim = {1'b0, period_limit} + {{CW{1'b0}}, 1'b1};
    if (pos >= lim) wrap_pos = CW'(pos - lim);
    else wrap_pos = pos[CW-1:0];
  endfunction

  // axi write: address and data taken independently, response after both
  assign s_axi_awready = !aw_ff && !bpend_ff;
  assign s_axi_wready  = !w_ff && !bpend_ff;
  assign s_axi_bvalid  = bpend_ff;
  assign s_axi_arready = !rpend_ff;
  assign s_axi_rvalid  = rpend_ff;
  wire logic wr_go = aw_ff && w_ff && !bpend_ff;
  wire logic [3:0] widx = awaddr_ff[5:2];
  wire logic wr_ctrl = wr_go && awaddr_ff == OFF_CTRL;
  wire logic wr_reg  = wr_go && awaddr_ff < OFF_STATUS && awaddr_ff[1:0] == 2'b00;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end else if (wr_go) begin
        w_ff <= 1'b0;
      end
    end
  end

  // response: slverr for unmapped addresses
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bpend_ff    <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      bpend_ff    <= 1'b1;
      s_axi_bresp <= wr_reg ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bpend_ff <= 1'b0;
    end
  end

  // register storage; low two byte lanes carry the 16-bit values
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NREG; i++) regs_ff[i] <= CNT_ZERO;
      regs_ff[1] <= PERIOD_RST;
      ctrl_ff    <= 6'h00;
    end else if (wr_reg) begin
      if (wr_ctrl) begin
        if (s_axi_wstrb[0]) ctrl_ff <= wdata_ff[5:0];
      end else begin
        if (s_axi_wstrb[0]) regs_ff[widx][7:0]  <= wdata_ff[7:0];
        if (s_axi_wstrb[1]) regs_ff[widx][15:8] <= wdata_ff[15:8];
      end
    end
  end

  // axi read
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rpend_ff    <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rpend_ff    <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > OFF_STATUS) begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end else if (s_axi_araddr == OFF_STATUS) begin
        s_axi_rdata <= {13'h0000, wrap_ff, pwm_output_second_o, pwm_output_first_o, count_ff};
      end else if (s_axi_araddr == OFF_CTRL) begin
        s_axi_rdata <= {26'h000_0000, ctrl_ff};
      end else begin
        s_axi_rdata <= {16'h0000, regs_ff[s_axi_araddr[5:2]]};
      end
    end else if (s_axi_rready) begin
      rpend_ff <= 1'b0;
    end
  end

  // period counter: zero up to period limit, then restart
  wire logic at_end = count_ff >= period;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_ff <= CNT_ZERO;
    end else if (!enable) begin
      count_ff <= CNT_ZERO;
    end else if (at_end) begin
      count_ff <= CNT_ZERO;
    end else begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // edge targets by mode; 16-bit sums, only the multi mode b fall is wrapped into the period
  logic [CW-1:0] a_rise, a_fall, b_rise, b_fall, adapt_t;
  logic          a_act, ad_act;
  logic [CW:0]   avg_dead;
  logic [CW+1:0] dsum;
  logic [CW-1:0] duty_eff;
  always_comb begin
    duty_eff = half_sel ? (filter_duty_i >> 1) : filter_duty_i;
    dsum     = {2'b00, ev3 - ev2} + {2'b00, ev1 + period - ev4};
    avg_dead = dsum[CW+1:1];
    a_act    = 1'b1;
    ad_act   = 1'b1;
    a_rise   = ev1;
    a_fall   = ev1 + filter_duty_i + adja;
    b_rise   = a_fall + (ev3 - ev2);
    b_fall   = ev4;
    adapt_t  = ev1 + duty_eff + adapt;
    case (mode)
      MODE_NORMAL: begin
        a_act = 1'b1;
      end
      MODE_MULTI: begin
        b_rise = ev3;
        b_fall = wrap_pos({1'b0, ev3} + {1'b0, filter_duty_i} + {1'b0, adjb}, period);
      end
      MODE_RESONANT: begin
        a_fall = ev1 + filter_duty_i - avg_dead[CW-1:0];
        b_rise = a_fall + (ev3 - ev2);
        b_fall = filter_period_i - (period - ev4);
      end
      MODE_TRIANGLE: begin
        a_act  = 1'b0;
        ad_act = 1'b0;
        b_rise = (period >> 1) - (filter_duty_i >> 1) + adja;
        b_fall = (period >> 1) + (filter_duty_i >> 1) + adjb;
      end
      MODE_LEADING: begin
        a_fall  = ev1;
        a_rise  = ev1 - filter_duty_i + adja;
        b_rise  = ev4;
        b_fall  = a_rise - (ev2 - ev3);
        adapt_t = ev1 - duty_eff + adapt;
      end
      default: begin
        a_act  = 1'b0;
        ad_act = 1'b0;
      end
    endcase
  end

  // compare units; each output changes when counter equals its target
  logic hit_ar, hit_af, hit_br, hit_bf, hit_ad, hit_ph, hit_s1, hit_s2;
  logic hit_aab, hit_aae, hit_bbb, hit_bbe;
  wire logic [CW-1:0] ph_t = ph_sel ? filter_duty_i : phreg;
  edge_match u_ar (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable && a_act),
                   .count_i(count_ff), .target_i(a_rise), .hit_o(hit_ar));
  edge_match u_af (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable && a_act),
                   .count_i(count_ff), .target_i(a_fall), .hit_o(hit_af));
  edge_match u_br (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable),
                   .count_i(count_ff), .target_i(b_rise), .hit_o(hit_br));
  edge_match u_bf (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable),
                   .count_i(count_ff), .target_i(b_fall), .hit_o(hit_bf));
  edge_match u_ad (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable && ad_act),
                   .count_i(count_ff), .target_i(adapt_t), .hit_o(hit_ad));
  edge_match u_ph (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable),
                   .count_i(count_ff), .target_i(ph_t), .hit_o(hit_ph));
  edge_match u_s1 (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable),
                   .count_i(count_ff), .target_i(regs_ff[10]), .hit_o(hit_s1));
  edge_match u_s2 (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable),
                   .count_i(count_ff), .target_i(regs_ff[11]), .hit_o(hit_s2));
  edge_match u_ab (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable),
                   .count_i(count_ff), .target_i(regs_ff[12]), .hit_o(hit_aab));
  edge_match u_ae (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable),
                   .count_i(count_ff), .target_i(regs_ff[13]), .hit_o(hit_aae));
  edge_match u_bb (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable),
                   .count_i(count_ff), .target_i(regs_ff[14]), .hit_o(hit_bbb));
  edge_match u_be (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(enable),
                   .count_i(count_ff), .target_i(regs_ff[15]), .hit_o(hit_bbe));

  assign adaptive_trig_o = hit_ad;
  assign phase_trig_o    = hit_ph;
  assign sample_trig1_o  = hit_s1;
  assign sample_trig2_o  = hit_s2;

  // period start pulse
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) period_start_o <= 1'b0;
    else period_start_o <= enable && count_ff == CNT_ZERO;
  end

  // output a: set on rise, clear on fall; fall wins when both match in the same cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwm_output_first_o <= 1'b0;
    end else if (!enable || !a_act || hit_af) begin
      pwm_output_first_o <= 1'b0;
    end else if (hit_ar) begin
      pwm_output_first_o <= 1'b1;
    end
  end

  // output b: the level carries across the period boundary when the fall wrapped
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwm_output_second_o <= 1'b0;
    end else if (!enable || hit_bf) begin
      pwm_output_second_o <= 1'b0;
    end else if (hit_br) begin
      pwm_output_second_o <= 1'b1;
    end
  end

  // wrap flag: b fall landed before its rise in multi mode
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) wrap_ff <= 1'b0;
    else wrap_ff <= mode == MODE_MULTI && b_fall < b_rise;
  end

  // blanking windows straight from their registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blank_a_o <= 1'b0;
      blank_b_o <= 1'b0;
    end else begin
      if (!enable || hit_aae) blank_a_o <= 1'b0;
      else if (hit_aab) blank_a_o <= 1'b1;
      if (!enable || hit_bbe) blank_b_o <= 1'b0;
      else if (hit_bbb) blank_b_o <= 1'b1;
    end
  end

  // checks
  property p_cnt_wrap;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (enable && at_end) |=> count_ff == CNT_ZERO;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter did not restart");

  // a rise match, then one cycle with unchanged settings while the hit is registered
  sequence s_a_rise_seen;
    (enable && a_act && count_ff == a_rise && count_ff != a_fall) ##1 $stable(ctrl_ff);
  endsequence

  property p_a_rise;
    @(posedge mclk_i) disable iff (!reset_n_i)
      s_a_rise_seen |=> pwm_output_first_o;
  endproperty
  a_a_rise: assert property (p_a_rise) else $error("output a missed rise");

  property p_a_fall;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (enable && count_ff == a_fall) |=> ##1 !pwm_output_first_o;
  endproperty
  a_a_fall: assert property (p_a_fall) else $error("output a missed fall");

  property p_tri_a;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (mode == MODE_TRIANGLE) |=> ##1 (!pwm_output_first_o || mode != MODE_TRIANGLE);
  endproperty
  a_tri_a: assert property (p_tri_a) else $error("output a active in triangle");

  property p_tri_ad;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (mode == MODE_TRIANGLE) |=> (!adaptive_trig_o || $past(mode) != MODE_TRIANGLE);
  endproperty
  a_tri_ad: assert property (p_tri_ad) else $error("adaptive trigger in triangle");

  property p_b_fall;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (enable && count_ff == b_fall) |=> ##1 !pwm_output_second_o;
  endproperty
  a_b_fall: assert property (p_b_fall) else $error("output b missed fall");

  property p_phase;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (enable && !ph_sel && count_ff == phreg) |=> phase_trig_o;
  endproperty
  a_phase: assert property (p_phase) else $error("phase trigger missing");

  property p_samp1;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (enable && count_ff == regs_ff[10]) |=> sample_trig1_o;
  endproperty
  a_samp1: assert property (p_samp1) else $error("sample trigger 1 missing");
endmodule

/* File: bench/filter_model.sv */
`timescale 1ns/1ps
// Purpose: loop filter stand-in feeding duty and period to the edge engine
// Assumes: requests change only between measured periods
// Notes: outputs are registered, so a new request lands one edge late
module filter_model
  import pwm_edge_pkg::*;
(
  input  wire logic [CW-1:0] duty_req_i,
  input  wire logic [CW-1:0] period_req_i,
  input  wire logic          resonant_i,
  input  wire logic          mclk_i,
  input  wire logic          reset_n_i,
  output logic [CW-1:0]      filter_duty_o,
  output logic [CW-1:0]      filter_period_o
);
  // resonant use needs period at twice duty for equal on-times
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      filter_duty_o   <= CNT_ZERO;
      filter_period_o <= CNT_ZERO;
    end else begin
      filter_duty_o   <= duty_req_i;
      filter_period_o <= resonant_i ? {duty_req_i[CW-2:0], 1'b0} : period_req_i;
    end
  end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
// Purpose: self-checking bench for the multimode pwm edge engine
// Assumes: a pulse shows one cycle after its match, so index k from period start is target k;
//          a level output passes one more flop and changes at index target + 1
// Notes: period kept at 120 so every target fits in one measured window
module tb_top
  import pwm_edge_pkg::*;
;
  logic          mclk_i;
  logic          reset_n_i;
  logic [7:0]    awaddr;
  logic [7:0]    araddr;
  logic [31:0]   wdata;
  logic          awvalid;
  logic          wvalid;
  logic          bready;
  logic          arvalid;
  logic          rready;
  logic          awready;
  logic          wready;
  logic          bvalid;
  logic          arready;
  logic          rvalid;
  logic [1:0]    bresp;
  logic [1:0]    rresp;
  logic [31:0]   rdata;
  logic [CW-1:0] duty_req;
  logic [CW-1:0] f_duty;
  logic [CW-1:0] f_period;
  logic          resonant_req;
  wire  [8:0]    sigs;
  logic [15:0]   rv [16];
  logic [31:0]   q;
  logic [1:0]    r;
  int            errors;
  int            samples_checked;
  int            seed;
  int            d;
  int            exp_r [9];
  int            exp_f [9];
  int            got_r [9];
  int            got_f [9];

  filter_model filter (.duty_req_i(duty_req), .period_req_i(16'h0078),
    .resonant_i(resonant_req), .mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .filter_duty_o(f_duty), .filter_period_o(f_period));

  multimode_pwm_edge_engine DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .filter_duty_i(f_duty), .filter_period_i(f_period),
    .pwm_output_first_o(sigs[0]), .pwm_output_second_o(sigs[1]),
    .adaptive_trig_o(sigs[2]), .phase_trig_o(sigs[3]), .sample_trig1_o(sigs[4]),
    .sample_trig2_o(sigs[5]), .blank_a_o(sigs[6]), .blank_b_o(sigs[7]),
    .period_start_o(sigs[8]));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic complete_run();
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic int rnd(input int n);
    return ($random(seed) & 32'h7fffffff) % n;
  endfunction

  // one bus transfer; ready is read at the negedge, which is what the next edge samples
  task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] dat,
                      output logic [31:0] rd, output logic [1:0] rs);
    bit ah;
    bit wh;
    bit dh;
    bit done;
    done = 0;
    @(posedge mclk_i);
    awaddr <= a;
    araddr <= a;
    wdata <= dat;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge mclk_i);
      ah = wr ? (awvalid && awready) : (arvalid && arready);
      wh = wvalid && wready;
      dh = wr ? bvalid : rvalid;
      rs = wr ? bresp : rresp;
      rd = rdata;
      @(posedge mclk_i);
      if (ah) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (wh) wvalid <= 1'b0;
      if (dh) begin
        bready <= 1'b0;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) begin
      errors++;
      complete_run();
    end
  endtask

  // skip the period in which settings changed and the one after it, then log edge indices of the next
  task automatic measure();
    logic [8:0] v;
    logic [8:0] pv;
    int n;
    v = sigs;
    repeat (2) begin
      n = 0;
      do begin
        @(negedge mclk_i);
        pv = v;
        v = sigs;
        n++;
      end while (!v[8] && n < 600);
      if (n >= 600) begin
        errors++;
        complete_run();
      end
    end
    for (int j = 0; j < 9; j++) begin
      got_r[j] = -1;
      got_f[j] = -1;
    end
    for (int k = 0; k <= rv[1] + 1; k++) begin
      if (k > 0) begin
        @(negedge mclk_i);
        pv = v;
        v = sigs;
      end
      for (int j = 0; j < 9; j++) begin
        if (k <= rv[1] || j == 8) begin
          if (v[j] && !pv[j]) got_r[j] = k;
          if (!v[j] && pv[j]) got_f[j] = k;
        end
      end
    end
  endtask

  function automatic void draw(input int m, input int it);
    rv[1] = 16'h0078;
    rv[2] = 16'(2 + rnd(4));
    rv[3] = 16'h000a;
    rv[4] = 16'(12 + rnd(4));
    rv[5] = 16'(100 + rnd(10));
    rv[6] = 16'(rnd(4));
    rv[7] = 16'(rnd(64));
    rv[8] = 16'(rnd(8));
    rv[9] = 16'(30 + rnd(50));
    rv[10] = 16'(1 + rnd(118));
    rv[11] = 16'(1 + rnd(118));
    rv[12] = 16'(1 + rnd(50));
    rv[13] = rv[12] + 16'(1 + rnd(50));
    rv[14] = 16'(1 + rnd(50));
    rv[15] = rv[14] + 16'(1 + rnd(50));
    d = 20 + rnd(20);
    case (m)
      1: begin
        rv[3] = 16'(rnd(65536));
        rv[4] = 16'(60 + rnd(10));
        rv[5] = 16'(rnd(65536));
      end
      2: begin
        rv[4] = 16'h000e;
        rv[5] = 16'(114 + rnd(4));
        d = 56 + rnd(5);
      end
      3: rv[7] = 16'(rnd(8));
      4: begin
        rv[2] = 16'(60 + rnd(4));
        rv[3] = 16'h000e;
        rv[4] = 16'h000a;
      end
      default: ;
    endcase
    // corner: second output wraps and falls exactly on count zero
    if (it == 6) rv[7] = 16'(121 - rv[4] - d);
    rv[0] = 16'(1 | (m << CTRL_MODE_LSB) | (rnd(2) << CTRL_HALF_BIT) | (rnd(2) << CTRL_PHSEL_BIT));
  endfunction

  function automatic void pulse(input int j, input int t);
    exp_r[j] = t;
    exp_f[j] = (t < 0) ? -1 : t + 1;
  endfunction

  function automatic void calc(input int m);
    int hd;
    int tg;
    int av;
    hd = rv[0][CTRL_HALF_BIT] ? d / 2 : d;
    tg = rv[2] + hd + rv[8];
    exp_r[0] = rv[2];
    exp_f[0] = rv[2] + d + rv[6];
    exp_r[1] = exp_f[0] + rv[4] - rv[3];
    exp_f[1] = rv[5];
    case (m)
      1: begin
        exp_r[1] = rv[4];
        exp_f[1] = (rv[4] + d + rv[7]) % (rv[1] + 1);
      end
      2: begin
        av = (rv[4] - rv[3] + rv[2] + rv[1] - rv[5]) / 2;
        exp_f[0] = rv[2] + d - av;
        exp_r[1] = exp_f[0] + rv[4] - rv[3];
        exp_f[1] = 2 * d - (rv[1] - rv[5]);
      end
      3: begin
        exp_r[0] = -1;
        exp_f[0] = -1;
        tg = -1;
        exp_r[1] = rv[1] / 2 - d / 2 + rv[6];
        exp_f[1] = rv[1] / 2 + d / 2 + rv[7];
      end
      4: begin
        exp_f[0] = rv[2];
        exp_r[0] = rv[2] - d + rv[6];
        tg = rv[2] - hd + rv[8];
        exp_r[1] = rv[5];
        exp_f[1] = exp_r[0] - (rv[3] - rv[4]);
      end
      default: ;
    endcase
    pulse(2, tg);
    pulse(3, rv[0][CTRL_PHSEL_BIT] ? d : int'(rv[9]));
    pulse(4, rv[10]);
    pulse(5, rv[11]);
    exp_r[6] = rv[12];
    exp_f[6] = rv[13];
    exp_r[7] = rv[14];
    exp_f[7] = rv[15];
    exp_r[8] = rv[1] + 1;
    exp_f[8] = 1;
    // outputs a, b and both blanking windows are one flop later than the trigger pulses
    foreach (exp_r[j]) begin
      if ((j < 2 || j == 6 || j == 7) && exp_r[j] >= 0) begin
        exp_r[j] += 1;
        exp_f[j] += 1;
      end
    end
  endfunction

  initial begin
    reset_n_i = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    duty_req = 16'h0000;
    resonant_req = 1'b0;
    errors = 0;
    samples_checked = 0;
    seed = 88956;
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    // reset contents, then a read-only write and an unmapped read
    for (int i = 0; i <= 16; i++) begin
      xfer(0, 8'(i * 4), 32'h0, q, r);
      chk("reset value", (i == 1) ? 32'(PERIOD_RST) : 32'h0, q);
      chk("read resp", 32'(RESP_OKAY), 32'(r));
    end
    xfer(1, OFF_STATUS, 32'h1, q, r);
    chk("status write resp", 32'(RESP_SLVERR), 32'(r));
    xfer(0, 8'h44, 32'h0, q, r);
    chk("unmapped read resp", 32'(RESP_SLVERR), 32'(r));
    // every mode three times; control written last so it switches with all else ready
    for (int it = 0; it < 15; it++) begin
      draw(it % 5, it);
      @(posedge mclk_i);
      duty_req <= 16'(d);
      resonant_req <= (it % 5 == 2);
      for (int i = 15; i >= 0; i--) xfer(1, 8'(i * 4), 32'(rv[i]), q, r);
      measure();
      calc(it % 5);
      for (int j = 0; j < 9; j++) begin
        chk($sformatf("rise index %0d", j), 32'(exp_r[j]), 32'(got_r[j]));
        chk($sformatf("fall index %0d", j), 32'(exp_f[j]), 32'(got_f[j]));
      end
    end
    complete_run();
  end
endmodule
